// >>> hw/pbs_regs.svh
// Purpose: constants for the pipelined burst sram core
// Assumes: 36-bit word built from four 9-bit lanes
// Notes:   no software registers; values describe pins and pipeline
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH

// ****************************************************
// widths
// ****************************************************
`define PBS_ADDR_W      18
`define PBS_DQ_W        32
`define PBS_BYTE_W      8
`define PBS_LANE_W      9
`define PBS_LANE_MAX    4
`define PBS_WORD_W      36
`define PBS_CNT_W       2

// ****************************************************
// configuration: 4 lanes for the wide part, 2 for x18
// ****************************************************
`define PBS_LANE_COUNT  4

// ****************************************************
// reset values
// ****************************************************
`define PBS_OE_N_RST    1'b1
`define PBS_DQ_RST      32'h0000_0000
`define PBS_PAR_RST     4'h0
`define PBS_WORD_RST    36'h0_0000_0000
`define PBS_CNT_RST     2'h0

// ****************************************************
// timing
// ****************************************************
`define PBS_CLK_PERIOD_NS 100
`define PBS_DATA_LATENCY  2

`endif

// >>> hw/pbs_pkg.sv
// Purpose: shared types of the pipelined burst sram core
// Assumes: pbs_regs.svh supplies all widths
// Notes:   types only, no numbers of their own
`include "pbs_regs.svh"

package pbs_pkg;

  typedef logic [`PBS_ADDR_W-1:0]   pbs_addr_t;
  typedef logic [`PBS_WORD_W-1:0]   pbs_word_t;
  typedef logic [`PBS_LANE_MAX-1:0] pbs_lane_t;
  typedef logic [`PBS_CNT_W-1:0]    pbs_cnt_t;
  typedef logic [`PBS_DQ_W-1:0]     pbs_dq_t;

  typedef enum logic [1:0] {
    PBS_ST_STOPPED,
    PBS_ST_BURST_READ,
    PBS_ST_BURST_WRITE
  } pbs_state_t;

endpackage

// >>> hw/pbs_mem.sv
// Purpose: word array with lane writes and a registered read port
// Assumes: caller gates both enables with the cycle enable
// Notes:   read before write when both hit one address in one edge
`timescale 1ns/1ps
`include "pbs_regs.svh"

module pbs_mem (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // write port
  input  wire logic              wr_en,
  input  wire pbs_pkg::pbs_addr_t wr_addr,
  input  wire pbs_pkg::pbs_lane_t wr_lane,
  input  wire pbs_pkg::pbs_word_t wr_data,
  // read port
  input  wire logic              rd_en,
  input  wire pbs_pkg::pbs_addr_t rd_addr,
  output pbs_pkg::pbs_word_t     rd_data
);
  import pbs_pkg::*;

  pbs_word_t rd_word;
  pbs_word_t rd_data_reg;

  // ****************************************************
  // lane writes
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < `PBS_LANE_MAX; g++) begin : g_lane
      // one array per lane keeps a single writer for each
      logic [`PBS_LANE_W-1:0] lane_array [0:(1<<`PBS_ADDR_W)-1];
      always_ff @(posedge clk) begin
        if (wr_en && wr_lane[g]) begin
          lane_array[wr_addr] <= wr_data[g*`PBS_LANE_W +: `PBS_LANE_W];
        end
      end
      assign rd_word[g*`PBS_LANE_W +: `PBS_LANE_W] = lane_array[rd_addr];
    end
  endgenerate

  // ****************************************************
  // registered read
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= `PBS_WORD_RST;
    end else if (rd_en) begin
      rd_data_reg <= rd_word;
    end
  end

  assign rd_data = rd_data_reg;

endmodule

// >>> hw/pbs_core.sv
// Purpose: command, burst and data pipeline of a pipelined sram
// Assumes: controller logic runs on CLK; its pins need no synchroniser
// Notes:   data bus is split into in, out and an active-low enable
`timescale 1ns/1ps
`include "pbs_regs.svh"

module pbs_core (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // cycle enable
  input  wire logic               CYCLE_ENABLE_N,
  // address and control
  input  wire pbs_pkg::pbs_addr_t ADDR,
  input  wire logic               READ_WRITE_SELECT,
  input  wire logic               ADVANCE_OR_LOAD,
  input  wire logic               CHIP_SELECT_1_N,
  input  wire logic               CHIP_SELECT_2,
  input  wire logic               CHIP_SELECT_3_N,
  input  wire pbs_pkg::pbs_lane_t BYTE_LANE_WRITE_N,
  // static burst order strap
  input  wire logic               LINEAR_ORDER_SELECT,
  // data bus, input side
  input  wire pbs_pkg::pbs_dq_t   DQ_IN,
  input  wire pbs_pkg::pbs_lane_t LANE_PARITY_BIT_IN,
  // data bus, output side
  output pbs_pkg::pbs_dq_t        DQ_OUT,
  output pbs_pkg::pbs_lane_t      LANE_PARITY_BIT_OUT,
  output logic                    DQ_OE_N
);
  import pbs_pkg::*;

  // ****************************************************
  // declarations
  // ****************************************************
  logic       ce;
  logic       selected;
  logic       is_load;
  logic       is_stop;
  logic       is_step;
  logic       iss_valid;
  logic       iss_write;
  pbs_addr_t  iss_addr;
  pbs_lane_t  iss_lane;
  pbs_lane_t  lane_mask;
  pbs_cnt_t   step_cnt;
  pbs_cnt_t   burst_low;
  pbs_word_t  in_word;
  pbs_word_t  mem_rd_data;
  pbs_word_t  out_word;
  logic       mem_wr_en;
  logic       mem_rd_en;
  logic       fwd_hit;
  logic       drive_next;

  logic       order_meta_reg;
  logic       order_sync_reg;

  pbs_state_t state_reg;
  pbs_state_t state_next;
  pbs_addr_t  base_reg;
  pbs_cnt_t   cnt_reg;
  pbs_cnt_t   cnt_next;

  logic       s1_valid_reg;
  logic       s1_write_reg;
  pbs_addr_t  s1_addr_reg;
  pbs_lane_t  s1_lane_reg;
  logic       s2_valid_reg;
  logic       s2_write_reg;
  pbs_addr_t  s2_addr_reg;
  pbs_lane_t  s2_lane_reg;

  logic       fwd_hit_reg;
  pbs_lane_t  fwd_lane_reg;
  pbs_word_t  fwd_data_reg;

  pbs_dq_t    dq_out_reg;
  pbs_lane_t  par_out_reg;
  logic       oe_n_reg;

  // ****************************************************
  // helpers
  // ****************************************************
  // modulo-four step of the burst counter
  function automatic pbs_cnt_t cnt_inc(input pbs_cnt_t c);
    cnt_inc = pbs_cnt_t'(c + 2'h1);
  endfunction

  // one lane of a packed word, parity bit on top
  function automatic logic [`PBS_LANE_W-1:0] lane_of(input pbs_word_t w,
                                                     input int        idx);
    lane_of = w[idx*`PBS_LANE_W +: `PBS_LANE_W];
  endfunction

  // ****************************************************
  // cycle enable and command decode
  // ****************************************************
  // edge blocked
  assign ce = !CYCLE_ENABLE_N;

  assign selected = !CHIP_SELECT_1_N && CHIP_SELECT_2 && !CHIP_SELECT_3_N;

  assign is_load = !ADVANCE_OR_LOAD && selected;
  assign is_stop = !ADVANCE_OR_LOAD && !selected;
  assign is_step = ADVANCE_OR_LOAD && (state_reg != PBS_ST_STOPPED);

  // ****************************************************
  // burst order strap synchroniser
  // ****************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      order_meta_reg <= 1'b0;
      order_sync_reg <= 1'b0;
    end else if (ce) begin
      order_meta_reg <= LINEAR_ORDER_SELECT;
      order_sync_reg <= order_meta_reg;
    end
  end

  // ****************************************************
  // burst state
  // ****************************************************
  always_comb begin
    state_next = state_reg;
    unique case (1'b1)
      is_load: begin
        state_next = READ_WRITE_SELECT ? PBS_ST_BURST_READ
                                       : PBS_ST_BURST_WRITE;
      end
      is_stop: begin
        state_next = PBS_ST_STOPPED;
      end
      ADVANCE_OR_LOAD: begin
        state_next = state_reg;
      end
    endcase
  end

  assign cnt_next = is_load ? `PBS_CNT_RST
                  : is_step ? cnt_inc(cnt_reg)
                  : cnt_reg;

  assign step_cnt = cnt_inc(cnt_reg);

  assign burst_low = order_sync_reg
                   ? (base_reg[`PBS_CNT_W-1:0] ^ step_cnt)
                   : pbs_cnt_t'(base_reg[`PBS_CNT_W-1:0] + step_cnt);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= PBS_ST_STOPPED;
      cnt_reg   <= `PBS_CNT_RST;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      base_reg <= '0;
    end else if (ce && is_load) begin
      base_reg <= ADDR;
    end
  end

  // ****************************************************
  // issued access
  // ****************************************************
  assign iss_valid = is_load || is_step;

  assign iss_write = is_load ? !READ_WRITE_SELECT
                             : (state_reg == PBS_ST_BURST_WRITE);

  assign iss_addr = is_load ? ADDR
                  : {base_reg[`PBS_ADDR_W-1:`PBS_CNT_W], burst_low};

  genvar g;
  generate
    for (g = 0; g < `PBS_LANE_MAX; g++) begin : g_mask
      assign lane_mask[g] = (g < `PBS_LANE_COUNT);
    end
  endgenerate

  assign iss_lane = iss_write ? (~BYTE_LANE_WRITE_N & lane_mask) : '0;

  // ****************************************************
  // two-stage pipeline
  // ****************************************************
  // enabled edges only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_valid_reg <= 1'b0;
      s1_write_reg <= 1'b0;
      s1_addr_reg  <= '0;
      s1_lane_reg  <= '0;
    end else if (ce) begin
      s1_valid_reg <= iss_valid;
      s1_write_reg <= iss_write;
      s1_addr_reg  <= iss_addr;
      s1_lane_reg  <= iss_lane;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s2_valid_reg <= 1'b0;
      s2_write_reg <= 1'b0;
      s2_addr_reg  <= '0;
      s2_lane_reg  <= '0;
    end else if (ce) begin
      s2_valid_reg <= s1_valid_reg;
      s2_write_reg <= s1_write_reg;
      s2_addr_reg  <= s1_addr_reg;
      s2_lane_reg  <= s1_lane_reg;
    end
  end

  // ****************************************************
  // data word packing
  // ****************************************************
  // byte plus parity
  generate
    for (g = 0; g < `PBS_LANE_MAX; g++) begin : g_pack
      assign in_word[g*`PBS_LANE_W +: `PBS_LANE_W] =
        {LANE_PARITY_BIT_IN[g], DQ_IN[g*`PBS_BYTE_W +: `PBS_BYTE_W]};
      assign out_word[g*`PBS_LANE_W +: `PBS_LANE_W] =
        (fwd_hit_reg && fwd_lane_reg[g])
          ? lane_of(fwd_data_reg, g)
          : lane_of(mem_rd_data, g);
    end
  endgenerate

  // ****************************************************
  // memory
  // ****************************************************
  // write at slot
  assign mem_wr_en = ce && s2_valid_reg && s2_write_reg;
  assign mem_rd_en = ce && s1_valid_reg && !s1_write_reg;

  pbs_mem u_mem (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr_en   (mem_wr_en),
    .wr_addr (s2_addr_reg),
    .wr_lane (s2_lane_reg),
    .wr_data (in_word),
    .rd_en   (mem_rd_en),
    .rd_addr (s1_addr_reg),
    .rd_data (mem_rd_data)
  );

  assign fwd_hit = s1_valid_reg && !s1_write_reg && mem_wr_en
                && (s1_addr_reg == s2_addr_reg);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fwd_hit_reg  <= 1'b0;
      fwd_lane_reg <= '0;
      fwd_data_reg <= `PBS_WORD_RST;
    end else if (ce) begin
      fwd_hit_reg  <= fwd_hit;
      fwd_lane_reg <= s2_lane_reg;
      fwd_data_reg <= in_word;
    end
  end

  // ****************************************************
  // output slot
  // ****************************************************
  // float on stop slot
  assign drive_next = s2_valid_reg && !s2_write_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_n_reg <= `PBS_OE_N_RST;
    end else if (ce) begin
      oe_n_reg <= !drive_next;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dq_out_reg  <= `PBS_DQ_RST;
      par_out_reg <= `PBS_PAR_RST;
    end else if (ce && drive_next) begin
      for (int i = 0; i < `PBS_LANE_MAX; i++) begin
        dq_out_reg[i*`PBS_BYTE_W +: `PBS_BYTE_W] <=
          out_word[i*`PBS_LANE_W +: `PBS_BYTE_W];
        par_out_reg[i] <= out_word[i*`PBS_LANE_W + `PBS_BYTE_W];
      end
    end
  end

  assign DQ_OUT              = dq_out_reg;
  assign LANE_PARITY_BIT_OUT = par_out_reg;
  assign DQ_OE_N             = oe_n_reg;

endmodule

// >>> test/pbs_chk.sv
// Purpose: pin assertions for the pipelined burst sram core
// Assumes: bound to pbs_core; slots counted in enabled edges
// Notes:   small command model tracks burst state and read slots
`timescale 1ns/1ps
module pbs_chk (
  // clock and reset
  input wire logic             CLK,
  input wire logic             RST_N,
  // command
  input wire logic             CYCLE_ENABLE_N,
  input wire logic             READ_WRITE_SELECT,
  input wire logic             ADVANCE_OR_LOAD,
  input wire logic             CHIP_SELECT_1_N,
  input wire logic             CHIP_SELECT_2,
  input wire logic             CHIP_SELECT_3_N,
  // data out
  input wire pbs_pkg::pbs_dq_t DQ_OUT,
  input wire logic             DQ_OE_N
);
  import pbs_pkg::*;
  logic       en;
  logic       sel;
  logic       ld_rd;
  logic       ld_wr;
  logic       go_rd;
  logic [1:0] st_reg;
  logic [2:0] p_reg;
  assign en = !CYCLE_ENABLE_N;
  assign sel = !CHIP_SELECT_1_N && CHIP_SELECT_2 && !CHIP_SELECT_3_N;
  assign ld_rd = en && !ADVANCE_OR_LOAD && sel && READ_WRITE_SELECT;
  assign ld_wr = en && !ADVANCE_OR_LOAD && sel && !READ_WRITE_SELECT;
  assign go_rd = ld_rd || (en && ADVANCE_OR_LOAD && st_reg == 2'h1);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= 2'h0;
      p_reg <= 3'h0;
    end else if (en) begin
      if (!ADVANCE_OR_LOAD)
        st_reg <= !sel ? 2'h0 : (READ_WRITE_SELECT ? 2'h1 : 2'h2);
      p_reg <= {p_reg[1:0], go_rd};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_slot_enable: assert property (DQ_OE_N == !p_reg[2])
    else $error("bus enable differs from read slot");
  a_suspend_hold: assert property (CYCLE_ENABLE_N |=>
    $stable(DQ_OE_N) && $stable(DQ_OUT)) else $error("suspend changed bus");
  a_read_slot: assert property (ld_rd ##1 en ##1 en |=> !DQ_OE_N)
    else $error("read slot not driven");
  a_desel_float: assert property (en && !ADVANCE_OR_LOAD && !sel
    ##1 en ##1 en |=> DQ_OE_N) else $error("deselect slot driven");
  a_noop_float: assert property (en && ADVANCE_OR_LOAD && st_reg == 2'h0
    ##1 en ##1 en |=> DQ_OE_N) else $error("no-op slot driven");
  a_write_float: assert property (ld_wr ##1 en ##1 en |=> DQ_OE_N)
    else $error("write slot driven");
  a_step_keeps_write: assert property (en && ADVANCE_OR_LOAD &&
    st_reg == 2'h2 && READ_WRITE_SELECT ##1 en ##1 en |=> DQ_OE_N)
    else $error("write burst turned to read");
  a_burst_read_runs: assert property (ld_rd ##1
    (en && ADVANCE_OR_LOAD)[*3] ##1 en[*2] |=> !DQ_OE_N)
    else $error("burst read slot missing");
  a_powerup_float: assert property ($rose(RST_N) |-> DQ_OE_N)
    else $error("bus driven after reset");
  c_turn: cover property (ld_rd ##1 ld_wr);
  c_hold: cover property (CYCLE_ENABLE_N && !DQ_OE_N);
  c_wstep: cover property (en && ADVANCE_OR_LOAD && st_reg == 2'h2);
endmodule

bind pbs_core pbs_chk i_pbs_chk (
  .CLK(CLK), .RST_N(RST_N), .CYCLE_ENABLE_N(CYCLE_ENABLE_N),
  .READ_WRITE_SELECT(READ_WRITE_SELECT), .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD),
  .CHIP_SELECT_1_N(CHIP_SELECT_1_N), .CHIP_SELECT_2(CHIP_SELECT_2),
  .CHIP_SELECT_3_N(CHIP_SELECT_3_N), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N));

// >>> test/pbs_ctl_model.sv
// Purpose: controller side of the data bus, write data supply
// Assumes: write word handed in with its command
// Notes:   bus toggles outside write slots
`timescale 1ns/1ps
module pbs_ctl_model (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // command seen
  input wire logic              cen_n,
  input wire logic              adv,
  input wire logic              rws,
  input wire logic              sel,
  input wire pbs_pkg::pbs_word_t wd,
  // bus
  output pbs_pkg::pbs_dq_t      dq,
  output pbs_pkg::pbs_lane_t    par
);
  import pbs_pkg::*;
  logic [1:0] st_reg;
  logic [1:0] v_reg;
  pbs_word_t  d1_reg;
  pbs_word_t  d2_reg;
  pbs_word_t  drv_reg = 36'h5_5555_5555;
  logic       wr_now;
  assign wr_now = (!adv && sel && !rws) || (adv && st_reg == 2'h2);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= 2'h0;
      v_reg <= 2'h0;
    end else if (!cen_n) begin
      if (!adv)
        st_reg <= !sel ? 2'h0 : (rws ? 2'h1 : 2'h2);
      v_reg <= {v_reg[0], wr_now};
      d1_reg <= wd;
      d2_reg <= d1_reg;
    end
  end
  // driven at falling edge, else toggling
  always @(negedge clk) drv_reg <= v_reg[1] ? d2_reg : ~drv_reg;
  assign dq = drv_reg[31:0];
  assign par = drv_reg[35:32];
endmodule

// >>> test/pbs_core_tb.sv
// Purpose: self-checking bench of the pipelined burst sram core
// Assumes: four lanes; word is {parity, data}
// Notes:   shadow memory and slot queue predict the bus
`timescale 1ns/1ps
module pbs_core_tb;
  import pbs_pkg::*;
  logic       clk = 0, rst_n = 0, cen_n = 1, adv = 0, rws = 0, lin = 0;
  logic [2:0] cs = 3'b110;
  pbs_addr_t  addr = 18'h0;
  pbs_lane_t  bw = 4'hF, pari, paro;
  pbs_word_t  wd = 36'h0;
  pbs_dq_t    dqi, dqo;
  logic       oe_n;
  int         n_mismatch = 0, cmp_count = 0;
  pbs_word_t  mem [pbs_addr_t];
  logic [36:0] q [$];
  logic [1:0] bst = 2'h0, k = 2'h0;
  pbs_addr_t  base = 18'h0;
  logic       lin_m = 0;
  pbs_lane_t  mk [6] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'h5};
  always #50 clk = ~clk;
  pbs_core i_pbs_core (.CLK(clk), .RST_N(rst_n), .CYCLE_ENABLE_N(cen_n),
    .ADDR(addr), .READ_WRITE_SELECT(rws), .ADVANCE_OR_LOAD(adv),
    .CHIP_SELECT_1_N(cs[2]), .CHIP_SELECT_2(cs[1]), .CHIP_SELECT_3_N(cs[0]),
    .BYTE_LANE_WRITE_N(bw), .LINEAR_ORDER_SELECT(lin), .DQ_IN(dqi),
    .LANE_PARITY_BIT_IN(pari), .DQ_OUT(dqo), .LANE_PARITY_BIT_OUT(paro),
    .DQ_OE_N(oe_n));
  pbs_ctl_model i_pbs_ctl_model (.clk(clk), .rst_n(rst_n), .cen_n(cen_n),
    .adv(adv), .rws(rws), .sel(cs == 3'b010), .wd(wd), .dq(dqi), .par(pari));
  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input logic a, r, input logic [2:0] c,
                     input pbs_addr_t ad, input pbs_lane_t b,
                     input pbs_word_t d);
    logic [36:0] e;
    pbs_addr_t   w;
    @(negedge clk);
    if (q.size() > 2) begin
      e = q.pop_front();
      chk({~oe_n, e[36] ? {paro, dqo} : 36'h0}, e);
    end
    {cen_n, adv, rws, cs, addr, bw, wd} = {1'b0, a, r, c, ad, b, d};
    if (!a) begin
      bst = c != 3'b010 ? 2'h0 : (r ? 2'h1 : 2'h2);
      base = ad;
      k = 2'h0;
    end else if (bst != 2'h0)
      k++;
    w = {base[17:2], lin_m ? base[1:0] ^ k : base[1:0] + k};
    if (bst == 2'h2)
      for (int i = 0; i < 4; i++)
        if (!b[i]) begin
          mem[w][8*i +: 8] = d[8*i +: 8];
          mem[w][32+i] = d[32+i];
        end
    q.push_back(bst == 2'h1 ? {1'b1, mem[w]} : 37'h0);
    @(posedge clk);
  endtask
  task automatic ld(input logic r, input pbs_addr_t ad, input pbs_lane_t b,
                    input pbs_word_t d);
    cyc(1'b0, r, 3'b010, ad, b, d);
  endtask
  task automatic stp(input logic r, input pbs_word_t d);
    cyc(1'b1, r, 3'b000, 18'h3FFFF, 4'h0, d);
  endtask
  task automatic ds(input logic [2:0] c);
    cyc(1'b0, 1'b1, c, 18'h3FFFF, 4'h0, 36'h0);
  endtask
  task automatic sus(input int n);
    logic [36:0] o;
    @(negedge clk);
    o = {oe_n, paro, dqo};
    cen_n = 1;
    repeat (n) begin
      @(posedge clk);
      @(negedge clk);
      chk({oe_n, paro, dqo}, o);
    end
  endtask
  task automatic t_lanes;
    ld(1'b0, 18'h00010, 4'h0, 36'hF_1234_5678);
    ld(1'b1, 18'h00010, 4'h0, 36'h0);
    for (int i = 0; i < 6; i++) begin
      ld(1'b0, 18'h00010, mk[i], 36'hA_9ABC_DEF0 + 36'(i * 7));
      ld(1'b1, 18'h00010, 4'hF, 36'h0);
    end
    repeat (3) ds(3'b110);
  endtask
  task automatic t_burst;
    ld(1'b0, 18'h20006, 4'h0, 36'h3_0000_0100);
    for (int i = 1; i < 5; i++)
      stp(i[0], 36'h3_0000_0100 + 36'(i));
    ld(1'b1, 18'h20006, 4'h0, 36'h0);
    repeat (3) stp(1'b0, 36'h0);
    @(negedge clk);
    cen_n = 1;
    lin = 1;
    ds(3'b110);
    ds(3'b110);
    lin_m = 1;
    ld(1'b1, 18'h20005, 4'h0, 36'h0);
    repeat (4) stp(1'b0, 36'h0);
    repeat (3) ds(3'b110);
  endtask
  task automatic t_desel;
    ld(1'b1, 18'h00010, 4'h0, 36'h0);
    ds(3'b110);
    ds(3'b000);
    ds(3'b011);
    stp(1'b1, 36'h0);
    stp(1'b1, 36'h0);
    repeat (3) ds(3'b110);
  endtask
  task automatic t_suspend;
    ld(1'b1, 18'h20006, 4'h0, 36'h0);
    ld(1'b0, 18'h00020, 4'h0, 36'h6_CAFE_0042);
    ds(3'b110);
    sus(3);
    ds(3'b110);
    sus(2);
    ld(1'b1, 18'h00020, 4'h0, 36'h0);
    repeat (3) ds(3'b110);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst_n = 1;
    @(negedge clk);
    chk(37'(oe_n), 37'h1);
    t_lanes();
    t_burst();
    t_desel();
    t_suspend();
    repeat (3) ds(3'b110);
    complete_run();
  end
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
